/* shared/fecp_consts.svh */
// constants for the flash ecc, protection and abort control block
`ifndef FECP_CONSTS_SVH
`define FECP_CONSTS_SVH

// register byte offsets (low 8 bits of the AXI address)
`define FECP_OFF_STATUS      8'h00
`define FECP_OFF_CMD         8'h08
`define FECP_OFF_KEY         8'h20
`define FECP_OFF_GUARD0      8'h28
`define FECP_OFF_GUARD1      8'h2C
`define FECP_OFF_SETUP       8'h38
`define FECP_OFF_AEN0        8'h48
`define FECP_OFF_AEN1        8'h4C
`define FECP_OFF_ECCCFG      8'h64
`define FECP_OFF_ECCADDR0    8'h74
`define FECP_OFF_ECCADDR1    8'h78
`define FECP_OFF_CSTAT       8'hC0
`define FECP_OFF_CSETUP      8'hC4
`define FECP_OFF_CKEY        8'hC8

// keys and values
`define FECP_USER_KEY        32'hF123_F456
`define FECP_LOCK_VALUE      32'h0000_003A
`define FECP_CMD_ABORT       4'h6
`define FECP_CMD_SIGN        4'h2
`define FECP_CMD_WRITE       4'h4
`define FECP_CMD_ERASE       4'h3

// status field positions
`define FECP_ST_DONE         2
`define FECP_ST_RES_LO       4
`define FECP_ST_SIGN_ECC_LO  7
`define FECP_ST_RD0_LO       9
`define FECP_ST_RD1_LO       11

// reset values and cache clear bit positions
`define FECP_GUARD_RST       32'hFFFF_FFFF
`define FECP_CACHE_RST       32'h0000_0002
`define FECP_ICACHE_BIT      0
`define FECP_DCACHE_BIT      16

// timing
`define FECP_CACHE_CLR_NS    1600
`define FECP_CLK_NS          100
`define FECP_CACHE_CLR_CYC   ((`FECP_CACHE_CLR_NS + `FECP_CLK_NS - 1) / `FECP_CLK_NS)

`endif

/* shared/fecp_pkg.sv */
// types for the flash ecc, protection and abort control block
`default_nettype none
package fecp_pkg;
    typedef enum logic [1:0] {FECP_RES_OK, FECP_RES_FAIL, FECP_RES_PROT, FECP_RES_ABORT} fecp_res_t;
    typedef enum {FECP_IDLE, FECP_BUSY} fecp_state_t;
endpackage
`default_nettype wire

/* logic/fecp_ecc_tally.sv */
// per-block ecc read error tally with capture of the failing address in interrupt mode (irq_mode)
`default_nettype none
module fecp_ecc_tally
    import fecp_pkg::*;
#(
    parameter int AW = 18
)
(
    // clock and reset
    input  wire logic          aclk,
    input  wire logic          aresetn,
    // ecc report from a normal read of this block
    input  wire logic          rd_valid,
    input  wire logic          single_err,
    input  wire logic          double_err,
    input  wire logic [AW-1:0] rd_addr,
    input  wire logic          report_en,
    input  wire logic          irq_mode,
    input  wire logic          clear,
    // state seen by software
    output logic [1:0]         field_ff,
    output logic [AW-1:0]      addr_ff
);
    logic hit;
    assign hit = rd_valid && report_en && (single_err || double_err);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            field_ff <= 2'h0;
        // a new error wins over a clear in the same cycle
        else if (hit)
            field_ff <= field_ff | {single_err, double_err};
        else if (clear)
            field_ff <= 2'h0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            addr_ff <= '0;
        else if (hit && irq_mode)
            addr_ff <= rd_addr;
    end
endmodule
`default_nettype wire

/* logic/fecp_ctrl.sv */
// flash ecc, key, protection, abort and cache control with AXI4-Lite registers
`default_nettype none
`include "fecp_consts.svh"
module fecp_ctrl
    import fecp_pkg::*;
#(
    parameter int AW       = 18,
    parameter int NIRQ     = 55,
    parameter int GUARD_W  = 32
)
(
    // clock and reset
    input  wire logic                aclk,
    input  wire logic                aresetn,
    // AXI4-Lite slave
    input  wire logic [7:0]          s_axi_awaddr,
    input  wire logic                s_axi_awvalid,
    output logic                     s_axi_awready,
    input  wire logic [31:0]         s_axi_wdata,
    input  wire logic [3:0]          s_axi_wstrb,
    input  wire logic                s_axi_wvalid,
    output logic                     s_axi_wready,
    output logic [1:0]               s_axi_bresp,
    output logic                     s_axi_bvalid,
    input  wire logic                s_axi_bready,
    input  wire logic [7:0]          s_axi_araddr,
    input  wire logic                s_axi_arvalid,
    output logic                     s_axi_arready,
    output logic [31:0]              s_axi_rdata,
    output logic [1:0]               s_axi_rresp,
    output logic                     s_axi_rvalid,
    input  wire logic                s_axi_rready,
    // flash array engine
    output logic                     op_start,
    output logic [3:0]               op_cmd,
    output logic                     op_abort,
    input  wire logic                op_done,
    input  wire logic                op_block,
    input  wire logic                op_target_prot,
    input  wire logic                op_cycle_done,
    // sign engine ecc and compare
    input  wire logic                sign_rd_valid,
    input  wire logic                sign_single_err,
    input  wire logic                sign_double_err,
    input  wire logic                sign_mismatch,
    // normal flash reads
    input  wire logic                rd_valid,
    input  wire logic                rd_block,
    input  wire logic [AW-1:0]       rd_addr,
    input  wire logic                rd_single_err,
    input  wire logic                rd_double_err,
    output logic                     rd_bus_error,
    output logic                     ecc_irq,
    // startup load and boot
    input  wire logic                boot_load,
    input  wire logic [GUARD_W-1:0]  boot_guard0,
    input  wire logic [GUARD_W-1:0]  boot_guard1,
    input  wire logic [31:0]         boot_lock0,
    input  wire logic [31:0]         boot_lock1,
    input  wire logic                kernel_running,
    // system
    input  wire logic [NIRQ-1:0]     sys_irq,
    input  wire logic                fetch_req,
    input  wire logic                fetch_block,
    output logic                     fetch_stall,
    output logic                     swd_enable,
    output logic                     cmd_irq,
    output logic                     icache_clear,
    output logic                     dcache_clear
);
    // write channel capture: address and data taken in either order
    logic [7:0]  aw_ff;
    logic        aw_have_ff;
    logic [31:0] w_ff;
    logic        w_have_ff;
    logic        bvalid_ff;
    logic        rvalid_ff;
    logic [31:0] rdata_ff;
    logic [1:0]  rresp_ff;
    logic        wr_go;
    logic [31:0] wd;
    logic        rd_go;

    assign s_axi_awready = !aw_have_ff && !bvalid_ff;
    assign s_axi_wready  = !w_have_ff && !bvalid_ff;
    assign s_axi_bvalid  = bvalid_ff;
    assign s_axi_bresp   = 2'h0;
    assign s_axi_arready = !rvalid_ff;
    assign s_axi_rvalid  = rvalid_ff;
    assign s_axi_rdata   = rdata_ff;
    assign s_axi_rresp   = rresp_ff;
    assign wr_go = aw_have_ff && w_have_ff && !bvalid_ff;
    assign rd_go = s_axi_arvalid && !rvalid_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            aw_have_ff <= 1'b0;
            aw_ff      <= 8'h00;
        end
        else if (s_axi_awvalid && s_axi_awready)
        begin
            aw_have_ff <= 1'b1;
            aw_ff      <= s_axi_awaddr;
        end
        else if (wr_go)
            aw_have_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            w_have_ff <= 1'b0;
            w_ff      <= 32'h0000_0000;
        end
        else if (s_axi_wvalid && s_axi_wready)
        begin
            w_have_ff <= 1'b1;
            w_ff      <= {{8{s_axi_wstrb[3]}}, {8{s_axi_wstrb[2]}}, {8{s_axi_wstrb[1]}}, {8{s_axi_wstrb[0]}}}
                         & s_axi_wdata;
        end
        else if (wr_go)
            w_have_ff <= 1'b0;
    end
    assign wd = w_ff;

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            bvalid_ff <= 1'b0;
        else if (wr_go)
            bvalid_ff <= 1'b1;
        else if (s_axi_bready)
            bvalid_ff <= 1'b0;
    end

    // register state
    logic               key_ff;
    logic               ckey_ff;
    logic [31:0]        setup_ff;
    logic [GUARD_W-1:0] guard0_ff;
    logic [GUARD_W-1:0] guard1_ff;
    logic [NIRQ-1:0]    aen_ff;
    logic [31:0]        ecccfg_ff;
    logic [31:0]        csetup_ff;
    logic [15:0]        cclr_cnt_ff;
    logic               done_ff;
    logic [1:0]         res_ff;
    logic [1:0]         sign_ecc_ff;
    logic [1:0]         sign_acc_ff;
    logic               swd_lock_ff;
    logic               kernel_d_ff;
    fecp_state_t        state_ff;
    logic [3:0]         cmd_ff;
    logic               blk_ff;
    logic               st_rd_clear;
    logic               wr_cmd;
    logic               wr_key;
    logic               irq_abort;
    logic               report_en;
    logic               irq_mode;
    logic [1:0]         fld0;
    logic [1:0]         fld1;
    logic [AW-1:0]      ea0;
    logic [AW-1:0]      ea1;

    assign wr_cmd     = wr_go && (aw_ff == `FECP_OFF_CMD);
    assign wr_key     = wr_go && (aw_ff == `FECP_OFF_KEY);
    // ecccfg bit 0: interrupt mode, bit 1: system exception mode
    assign irq_mode   = ecccfg_ff[0];
    assign report_en  = ecccfg_ff[0] || ecccfg_ff[1];
    assign irq_abort  = |(sys_irq & aen_ff);
    assign st_rd_clear = rd_go && (s_axi_araddr == `FECP_OFF_STATUS);

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            key_ff <= 1'b0;
        else if (wr_key)
            key_ff <= (wd == `FECP_USER_KEY);
        else if (wr_cmd)
            key_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
            ckey_ff <= 1'b0;
        else if (wr_go && aw_ff == `FECP_OFF_CKEY)
            ckey_ff <= (wd == `FECP_USER_KEY);
        else if (wr_go && aw_ff == `FECP_OFF_CSETUP)
            ckey_ff <= 1'b0;
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            setup_ff  <= 32'h0000_0001;
            guard0_ff <= GUARD_W'(`FECP_GUARD_RST);
            guard1_ff <= GUARD_W'(`FECP_GUARD_RST);
            aen_ff    <= '0;
            ecccfg_ff <= 32'h0000_0000;
        end
        else if (boot_load)
        begin
            guard0_ff <= boot_guard0;
            guard1_ff <= boot_guard1;
        end
        else if (wr_go)
        begin
            case (aw_ff)
                `FECP_OFF_SETUP:  if (key_ff) setup_ff <= wd;
                `FECP_OFF_GUARD0: if (key_ff) guard0_ff <= wd[GUARD_W-1:0];
                `FECP_OFF_GUARD1: if (key_ff) guard1_ff <= wd[GUARD_W-1:0];
                `FECP_OFF_AEN0:   aen_ff[31:0] <= wd;
                `FECP_OFF_AEN1:   aen_ff[NIRQ-1:32] <= wd[NIRQ-33:0];
                `FECP_OFF_ECCCFG: ecccfg_ff <= wd;
                default:          ;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            kernel_d_ff <= 1'b1;
            swd_lock_ff <= 1'b0;
        end
        else
        begin
            kernel_d_ff <= kernel_running;
            if (kernel_d_ff && !kernel_running)
                swd_lock_ff <= (boot_lock0 == `FECP_LOCK_VALUE) || (boot_lock1 == `FECP_LOCK_VALUE);
        end
    end
    assign swd_enable = setup_ff[0] && !swd_lock_ff && !kernel_running;

    // command sequencer
    logic start_ok;
    logic protected_cmd;
    assign protected_cmd = (wd[3:0] == `FECP_CMD_WRITE) || (wd[3:0] == `FECP_CMD_ERASE)
                           || (wd[3:0] == `FECP_CMD_SIGN);
    assign start_ok = wr_cmd && protected_cmd && key_ff && state_ff == FECP_IDLE;
    // a refused command never reaches the array engine
    assign op_start = start_ok && !irq_abort && !op_target_prot;
    assign op_cmd   = wd[3:0];
    assign op_abort = state_ff == FECP_BUSY && (irq_abort || (wr_cmd && wd[3:0] == `FECP_CMD_ABORT));

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            state_ff <= FECP_IDLE;
            cmd_ff   <= 4'h0;
            blk_ff   <= 1'b0;
        end
        else
        begin
            case (state_ff)
                FECP_IDLE:
                    if (start_ok && !irq_abort && !op_target_prot)
                    begin
                        state_ff <= FECP_BUSY;
                        cmd_ff   <= wd[3:0];
                        blk_ff   <= op_block;
                    end
                FECP_BUSY:
                    if (op_done || op_abort)
                        state_ff <= FECP_IDLE;
                default:
                    state_ff <= FECP_IDLE;
            endcase
        end
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            done_ff <= 1'b0;
            res_ff  <= FECP_RES_OK;
        end
        else if (start_ok && op_target_prot)
        begin
            done_ff <= 1'b1;
            res_ff  <= FECP_RES_PROT;
        end
        else if (start_ok && irq_abort)
        begin
            done_ff <= 1'b1;
            res_ff  <= FECP_RES_ABORT;
        end
        else if (op_abort)
        begin
            done_ff <= 1'b1;
            res_ff  <= (irq_abort || !op_cycle_done) ? FECP_RES_ABORT : FECP_RES_OK;
        end
        else if (state_ff == FECP_BUSY && op_done)
        begin
            done_ff <= 1'b1;
            res_ff  <= (cmd_ff == `FECP_CMD_SIGN && sign_mismatch) ? FECP_RES_FAIL : FECP_RES_OK;
        end
        else if (st_rd_clear)
        begin
            done_ff <= 1'b0;
        end
    end
    // irq if command irq enabled (setup bit 1)
    assign cmd_irq = done_ff && setup_ff[1];

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            sign_acc_ff <= 2'h0;
            sign_ecc_ff <= 2'h0;
        end
        else if (state_ff == FECP_BUSY && cmd_ff == `FECP_CMD_SIGN)
        begin
            if (sign_rd_valid)
                sign_acc_ff <= sign_acc_ff | {sign_single_err, sign_double_err};
            if (op_done || op_abort)
            begin
                sign_ecc_ff <= sign_acc_ff | ({2{sign_rd_valid}} & {sign_single_err, sign_double_err});
                sign_acc_ff <= 2'h0;
            end
        end
        else if (start_ok)
            sign_ecc_ff <= 2'h0;
    end

    fecp_ecc_tally #(.AW(AW)) u_tally0 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .rd_valid   (rd_valid && !rd_block),
        .single_err (rd_single_err),
        .double_err (rd_double_err),
        .rd_addr    (rd_addr),
        .report_en  (report_en),
        .irq_mode   (irq_mode),
        .clear      (st_rd_clear),
        .field_ff   (fld0),
        .addr_ff    (ea0)
    );
    fecp_ecc_tally #(.AW(AW)) u_tally1 (
        .aclk       (aclk),
        .aresetn    (aresetn),
        .rd_valid   (rd_valid && rd_block),
        .single_err (rd_single_err),
        .double_err (rd_double_err),
        .rd_addr    (rd_addr),
        .report_en  (report_en),
        .irq_mode   (irq_mode),
        .clear      (st_rd_clear),
        .field_ff   (fld1),
        .addr_ff    (ea1)
    );
    assign rd_bus_error = rd_valid && rd_double_err && ecccfg_ff[1];
    assign ecc_irq      = irq_mode && ((|fld0) || (|fld1));

    // cache init on keyed setup write
    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            csetup_ff   <= `FECP_CACHE_RST;
            cclr_cnt_ff <= 16'h0000;
        end
        else if (wr_go && aw_ff == `FECP_OFF_CSETUP && ckey_ff)
        begin
            csetup_ff   <= wd;
            cclr_cnt_ff <= 16'(`FECP_CACHE_CLR_CYC);
        end
        else if (cclr_cnt_ff != 16'h0000)
            cclr_cnt_ff <= cclr_cnt_ff - 16'h0001;
    end
    assign icache_clear = (cclr_cnt_ff != 16'h0000) && csetup_ff[`FECP_ICACHE_BIT];
    assign dcache_clear = (cclr_cnt_ff != 16'h0000) && csetup_ff[`FECP_DCACHE_BIT];

    assign fetch_stall = fetch_req && state_ff == FECP_BUSY && fetch_block == blk_ff;

    // read mux; status read clears the done flag and both blocks' read ecc fields
    logic [31:0] rmux;
    logic        rhit;
    always_comb
    begin
        rmux = 32'h0000_0000;
        rhit = 1'b1;
        case (s_axi_araddr)
            `FECP_OFF_STATUS:   rmux = {19'h0, fld1, fld0, sign_ecc_ff, 1'b0, res_ff, 1'b0, done_ff, 1'b0,
                                        state_ff == FECP_BUSY};
            `FECP_OFF_CMD:      rmux = {28'h0, cmd_ff};
            `FECP_OFF_KEY:      rmux = 32'h0000_0000;
            `FECP_OFF_GUARD0:   rmux = 32'(guard0_ff);
            `FECP_OFF_GUARD1:   rmux = 32'(guard1_ff);
            `FECP_OFF_SETUP:    rmux = setup_ff;
            `FECP_OFF_AEN0:     rmux = aen_ff[31:0];
            `FECP_OFF_AEN1:     rmux = 32'(aen_ff[NIRQ-1:32]);
            `FECP_OFF_ECCCFG:   rmux = ecccfg_ff;
            `FECP_OFF_ECCADDR0: rmux = 32'(ea0);
            `FECP_OFF_ECCADDR1: rmux = 32'(ea1);
            `FECP_OFF_CSTAT:    rmux = csetup_ff & {32{icache_clear || dcache_clear}};
            `FECP_OFF_CSETUP:   rmux = csetup_ff;
            `FECP_OFF_CKEY:     rmux = 32'h0000_0000;
            default:            rhit = 1'b0;
        endcase
    end

    always_ff @(posedge aclk)
    begin
        if (!aresetn)
        begin
            rvalid_ff <= 1'b0;
            rdata_ff  <= 32'h0000_0000;
            rresp_ff  <= 2'h0;
        end
        else if (rd_go)
        begin
            rvalid_ff <= 1'b1;
            rdata_ff  <= rmux;
            rresp_ff  <= rhit ? 2'h0 : 2'h2;
        end
        else if (s_axi_rready)
            rvalid_ff <= 1'b0;
    end

    // assertions
    property p_key_clear;
        @(posedge aclk) disable iff (!aresetn)
        wr_cmd && !wr_key |=> !key_ff;
    endproperty
    a_key_clear: assert property (p_key_clear) else $error("key not cleared by command");

    property p_refuse;
        @(posedge aclk) disable iff (!aresetn)
        wr_cmd && !key_ff |-> !op_start;
    endproperty
    a_refuse: assert property (p_refuse) else $error("command started without key");

    property p_irq_abort;
        @(posedge aclk) disable iff (!aresetn)
        op_abort && irq_abort |=> res_ff == FECP_RES_ABORT && done_ff;
    endproperty
    a_irq_abort: assert property (p_irq_abort) else $error("interrupt abort result wrong");

    property p_done;
        @(posedge aclk) disable iff (!aresetn)
        state_ff == FECP_BUSY && op_done && !op_abort |=> done_ff && state_ff == FECP_IDLE;
    endproperty
    a_done: assert property (p_done) else $error("done bit not set");

    property p_stall;
        @(posedge aclk) disable iff (!aresetn)
        fetch_req && state_ff == FECP_BUSY && fetch_block == blk_ff |-> fetch_stall;
    endproperty
    a_stall: assert property (p_stall) else $error("same block fetch not stalled");

    property p_held_abort;
        @(posedge aclk) disable iff (!aresetn)
        irq_abort && start_ok |-> !op_start ##1 state_ff == FECP_IDLE;
    endproperty
    a_held_abort: assert property (p_held_abort) else $error("command ran during held abort");

    property p_buserr;
        @(posedge aclk) disable iff (!aresetn)
        rd_valid && rd_double_err && ecccfg_ff[1] |-> rd_bus_error;
    endproperty
    a_buserr: assert property (p_buserr) else $error("missing bus error");

    sequence s_cache_go;
        wr_go && aw_ff == `FECP_OFF_CSETUP && ckey_ff && wd[`FECP_ICACHE_BIT];
    endsequence
    property p_cache;
        @(posedge aclk) disable iff (!aresetn)
        s_cache_go |=> icache_clear ##[1:20] !icache_clear;
    endproperty
    a_cache: assert property (p_cache) else $error("cache clear sequence wrong");
endmodule
`default_nettype wire

/* test/fecp_eng_model.sv */
// flash array engine model that finishes a command after a short delay
`default_nettype none
module fecp_eng_model (
    // clock and reset
    input  wire logic aclk,
    input  wire logic aresetn,
    // command handshake
    input  wire logic op_start,
    input  wire logic op_abort,
    output logic      op_done,
    output logic      op_cycle_done
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [2:0] cnt_ff;
    // an abort drops the count, so the cycle stays unfinished
    always_ff @(posedge aclk)
    begin
        if (!aresetn || op_abort)
            cnt_ff <= 3'h0;
        else if (op_start)
            cnt_ff <= 3'h5;
        else if (cnt_ff != 3'h0)
            cnt_ff <= cnt_ff - 3'h1;
    end
    assign op_done       = (cnt_ff == 3'h1);
    assign op_cycle_done = op_done;
endmodule
`default_nettype wire

/* test/flash_ecc_protect_abort_tb.sv */
// register level bench for the flash ecc, key, abort control block
`default_nettype none
`include "fecp_consts.svh"
module flash_ecc_protect_abort_tb;
    timeunit 1ns;
    timeprecision 1ns;
    logic aclk = 0, aresetn = 0, kernel_running = 1;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0, s_axi_arvalid = 0, s_axi_rready = 0;
    logic op_block = 0, op_target_prot = 0, sign_rd_valid = 0, sign_single_err = 0, sign_double_err = 0;
    logic sign_mismatch = 0, rd_valid = 0, rd_block = 0, rd_single_err = 0, rd_double_err = 0, boot_load = 0;
    logic fetch_req = 0, fetch_block = 0;
    logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, boot_guard0 = 0, boot_guard1 = 0, boot_lock0 = 0, boot_lock1 = 0;
    logic [3:0] s_axi_wstrb = 4'hF;
    logic [17:0] rd_addr = 0;
    logic [54:0] sys_irq = 0;
    wire logic op_done, op_cycle_done;
    logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, op_start, op_abort;
    logic rd_bus_error, ecc_irq, fetch_stall, swd_enable, cmd_irq, icache_clear, dcache_clear;
    logic [1:0] s_axi_bresp, s_axi_rresp, r;
    logic [31:0] s_axi_rdata, d;
    logic [3:0] op_cmd;
    int num_errors = 0, num_checks = 0;
    fecp_ctrl dut_u (.*);
    fecp_eng_model eng_u (.*);
    initial forever #50 aclk = ~aclk;
    task automatic final_report();
        if (num_errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
        num_checks++;
        if (g !== e)
        begin
            $display("unexpected %s exp %h got %h", nm, e, g);
            num_errors++;
        end
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] v);
        logic ta, tw, tb;
        tb = 0;
        s_axi_awaddr <= a;
        s_axi_wdata <= v;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (int n = 0; n < 40 && !tb; n++)
        begin
            @(negedge aclk);
            ta = s_axi_awready;
            tw = s_axi_wready;
            tb = s_axi_bvalid;
            @(posedge aclk);
            if (ta) s_axi_awvalid <= 0;
            if (tw) s_axi_wvalid <= 0;
            if (tb) s_axi_bready <= 0;
        end
        if (!tb) chk("bvalid", 1, 0);
        if (!tb) final_report();
    endtask
    task automatic rc(input logic [7:0] a, input logic [31:0] m, input logic [31:0] e, input string nm);
        logic ta, tb;
        tb = 0;
        s_axi_araddr <= a;
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (int n = 0; n < 40 && !tb; n++)
        begin
            @(negedge aclk);
            ta = s_axi_arready;
            tb = s_axi_rvalid;
            d = s_axi_rdata;
            r = s_axi_rresp;
            @(posedge aclk);
            if (ta) s_axi_arvalid <= 0;
            if (tb) s_axi_rready <= 0;
        end
        if (!tb) chk("rvalid", 1, 0);
        if (!tb) final_report();
        chk(nm, e, d & m);
    endtask
    // command, keyed only when key is set, then a wait longer than the engine model delay
    task automatic cmd(input logic key, input logic [3:0] c);
        if (key) wr(`FECP_OFF_KEY, `FECP_USER_KEY);
        wr(`FECP_OFF_CMD, {28'h0, c});
        repeat (12) @(posedge aclk);
    endtask
    initial
    begin
        repeat (8) @(posedge aclk);
        aresetn <= 1;
        @(posedge aclk);
        rc(`FECP_OFF_GUARD0, 32'hFFFF_FFFF, `FECP_GUARD_RST, "guard0");
        boot_guard1 <= 32'h0000_0F0F;
        boot_load <= 1;
        @(posedge aclk);
        boot_load <= 0;
        rc(`FECP_OFF_GUARD1, 32'hFFFF_FFFF, 32'h0000_0F0F, "bootguard");
        rc(`FECP_OFF_CSETUP, 32'hFFFF_FFFF, `FECP_CACHE_RST, "csetup");
        rc(8'h10, 32'h0000_0000, 32'h0000_0000, "unmapped");
        chk("rresp", 32'h0000_0002, {30'h0, r});
        kernel_running <= 0;
        repeat (2) @(posedge aclk);
        chk("swd", 32'h0000_0001, {31'h0, swd_enable});
        cmd(0, `FECP_CMD_WRITE);
        rc(`FECP_OFF_STATUS, 32'h0000_0005, 32'h0000_0000, "nokey");
        cmd(1, `FECP_CMD_WRITE);
        rc(`FECP_OFF_STATUS, 32'h0000_0035, 32'h0000_0004, "done");
        cmd(0, `FECP_CMD_ERASE);
        rc(`FECP_OFF_STATUS, 32'h0000_0005, 32'h0000_0000, "keyused");
        wr(`FECP_OFF_KEY, `FECP_USER_KEY);
        wr(`FECP_OFF_KEY, 32'h0000_0000);
        cmd(0, `FECP_CMD_SIGN);
        rc(`FECP_OFF_STATUS, 32'h0000_0005, 32'h0000_0000, "keycleared");
        wr(`FECP_OFF_KEY, `FECP_USER_KEY);
        wr(`FECP_OFF_CMD, {28'h0, `FECP_CMD_WRITE});
        cmd(0, `FECP_CMD_ABORT);
        rc(`FECP_OFF_STATUS, 32'h0000_0035, 32'h0000_0034, "abortcmd");
        wr(`FECP_OFF_KEY, `FECP_USER_KEY);
        wr(`FECP_OFF_CMD, {28'h0, `FECP_CMD_WRITE});
        fetch_req <= 1;
        @(posedge aclk);
        chk("stall", 1, {31'h0, fetch_stall});
        fetch_block <= 1;
        @(posedge aclk);
        chk("otherblock", 0, {31'h0, fetch_stall});
        fetch_req <= 0;
        repeat (12) @(posedge aclk);
        rc(`FECP_OFF_STATUS, 32'h0000_0035, 32'h0000_0004, "redone");
        wr(`FECP_OFF_AEN0, 32'h0000_0001);
        wr(`FECP_OFF_KEY, `FECP_USER_KEY);
        wr(`FECP_OFF_CMD, {28'h0, `FECP_CMD_ERASE});
        sys_irq <= 55'h1;
        repeat (12) @(posedge aclk);
        rc(`FECP_OFF_STATUS, 32'h0000_0035, 32'h0000_0034, "abortbusy");
        for (int i = 0; i < 3; i++)
        begin
            cmd(1, i == 0 ? `FECP_CMD_WRITE : i == 1 ? `FECP_CMD_ERASE : `FECP_CMD_SIGN);
            rc(`FECP_OFF_STATUS, 32'h0000_0035, 32'h0000_0034, "abortirq");
        end
        sys_irq <= 55'h0;
        for (int c = 0; c < 2; c++)
        begin
            wr(`FECP_OFF_ECCCFG, c);
            rd_valid <= 1;
            rd_single_err <= 1;
            rd_addr <= 18'h0_0123;
            @(posedge aclk);
            rd_valid <= 0;
            @(posedge aclk);
            chk("eccirq", c, {31'h0, ecc_irq});
            rc(`FECP_OFF_STATUS, 32'h0000_0600, c ? 32'h0000_0400 : 32'h0, "rderr");
        end
        rc(`FECP_OFF_ECCADDR0, 32'h0003_FFFF, 32'h0000_0123, "eccaddr");
        sign_rd_valid <= 1;
        sign_single_err <= 1;
        sign_mismatch <= 1;
        cmd(1, `FECP_CMD_SIGN);
        sign_rd_valid <= 0;
        rc(`FECP_OFF_STATUS, 32'h0000_1FB5, 32'h0000_0114, "sign");
        chk("signirq", 0, {31'h0, ecc_irq});
        wr(`FECP_OFF_ECCCFG, 32'h0000_0002);
        rd_valid <= 1;
        rd_block <= 1;
        rd_double_err <= 1;
        @(posedge aclk);
        chk("buserr", 1, {31'h0, rd_bus_error});
        rd_valid <= 0;
        rc(`FECP_OFF_STATUS, 32'h0000_1E00, 32'h0000_1800, "rderr1");
        wr(`FECP_OFF_KEY, `FECP_USER_KEY);
        wr(`FECP_OFF_SETUP, 32'h0000_0002);
        chk("swdoff", 0, {31'h0, swd_enable});
        op_target_prot <= 1;
        cmd(1, `FECP_CMD_WRITE);
        chk("cmdirq", 1, {31'h0, cmd_irq});
        rc(`FECP_OFF_STATUS, 32'h0000_0035, 32'h0000_0024, "prot");
        op_target_prot <= 0;
        wr(`FECP_OFF_CKEY, `FECP_USER_KEY);
        wr(`FECP_OFF_CSETUP, 32'h0001_0003);
        chk("caches", 3, {30'h0, dcache_clear, icache_clear});
        rc(`FECP_OFF_CSTAT, 32'h0001_0001, 32'h0001_0001, "cbusy");
        repeat (20) @(posedge aclk);
        rc(`FECP_OFF_CSTAT, 32'h0001_0001, 32'h0000_0000, "cdone");
        final_report();
    end
endmodule
`default_nettype wire
